// file: rtl/csc_pkg.sv
package csc_pkg;

    // Serial slave address, seven bits; write byte 1101 0010
    localparam logic [6:0] SLAVE_ADDR = 7'h69;

    // Byte positions after the address byte in a write transfer
    localparam logic [7:0] IDX_CMD_CODE = 8'h00;
    localparam logic [7:0] IDX_BYTE_COUNT = 8'h01;
    localparam logic [7:0] IDX_FIRST_REG = 8'h02;

    // Register indices in the stored byte sequence
    localparam logic [7:0] REG_FREQ_SEL_CTRL = 8'h00;
    localparam logic [7:0] REG_HOST_CLOCK_EN = 8'h01;

    // True power-up values, and the fixed readback of unimplemented bytes
    localparam logic [7:0] FREQ_SEL_CTRL_RESET = 8'h00;
    localparam logic [7:0] HOST_CLOCK_EN_RESET = 8'hFF;
    localparam logic [7:0] UNIMPL_READ_VALUE = 8'h00;

    // Field positions of the frequency select control register
    localparam int SS_NARROW_BIT = 7;
    localparam int SOFT_SEL_MSB = 6;
    localparam int SOFT_SEL_LSB = 4;
    localparam int SOFT_SEL_EN_BIT = 3;
    localparam int SS_DOWN_BIT = 2;
    localparam int SS_ENABLE_BIT = 1;
    localparam int TRISTATE_BIT = 0;

    // Field of the host clock enable register
    localparam int HOST_EN_MSB = 3;

    // Bits per serial byte and cycles before the straps are caught
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [4:0] {
        CSC_IDLE = 5'b00001,
        CSC_RECV = 5'b00010,
        CSC_ACK = 5'b00100,
        CSC_SEND = 5'b01000,
        CSC_RACK = 5'b10000
    } csc_serial_state_type;

    // Pins latched at power up: {voltage, mode, freq bit2..bit0}
    typedef struct packed {
        logic host_output_voltage_strap;
        logic mode_strap;
        logic [2:0] strap_freq_sel;
    } csc_strap_type;

    // Settings that steer the synthesizer
    typedef struct packed {
        logic [2:0] freq_code;
        logic spread_enable;
        logic spread_down;
        logic spread_narrow;
        logic tristate_all;
    } csc_synth_cfg_type;

endpackage

// file: rtl/csc_clock_control.sv
// Operation
// (R1) Each clock output has its own enable bit; here only the four host clocks have one, graphics and peripheral have none
// (R2) Controller waits 3 ms before enabling outputs
// (R3) Mode strap 0 turns shared pins into halts
// (R4) Halted clock runs only if bit and pin allow
// (R5) Stopped clocks held low, full last high
// (R6) Stop changes follow free peripheral clock rising edge
// (R7) Host halt stops host, graphics; other halts peripheral
// (R8) Stored bytes can be read back by controller
// (R9) Controller sends all preceding bytes to change one
// (R10) Defaults loaded; works without any serial access
// (R11) Acknowledge each received byte by pulling data low
// (R12) Write: address, command, count, then register bytes
// (R13) Command and count bytes ignored but acknowledged
// (R14) Read returns bytes from byte zero onward
// (R15) Defaults loaded only by true power up
// (R16) Register 0 bit 7 selects spread deviation
// (R17) Register 0 bit 3 picks strap or software
// (R18) Three-bit code selects the frequency set
// (R19) Register 0 bit 2 selects spread type
// (R20) Register 0 bit 1 enables spread modulation
// (R21) Register 0 bit 0 tristates all outputs
// (R22) Register 1 bits 3:0 enable host clocks
// (R23) Frequency straps latched at power up
// (R24) Mode strap latched at power up
// (R25) Bytes past last register acked and dropped
`timescale 1ns/10ps
`default_nettype none

module csc_clock_control
(
    // System clock and power-up reset
    input wire logic clock,
    input wire logic sys_rst,
    // Free-running peripheral clock, clocks the stop logic
    input wire logic free_running_periph_clock,
    // Serial control pins
    input wire logic serial_clock_line,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    // Strap pins, meaningful only around power up
    input wire csc_pkg::csc_strap_type strap_pins,
    // Halt inputs on the shared memory clock pins
    input wire logic host_halt_n,
    input wire logic periph_halt_n,
    // Synthesizer settings, host voltage select and halt pin function
    output csc_pkg::csc_synth_cfg_type synth_cfg,
    output logic host_output_voltage_sel,
    output logic halt_pins_active,
    // Gate enables, changed on free-running clock rising edges
    output logic [3:0] host_clock_out_run,
    output logic graphics_clock_run,
    output logic periph_clock_run
);

    typedef struct packed {
        csc_pkg::csc_serial_state_type st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] idx;
        logic rw;
        logic is_addr;
        logic mack;
        logic sda_oe_n;
        logic scl_m;
        logic scl_s;
        logic scl_q;
        logic sda_m;
        logic sda_s;
        logic sda_q;
        logic [4:0] strap_m;
        logic [4:0] strap_s;
        logic [1:0] strap_cnt;
        logic straps_ok;
        csc_pkg::csc_strap_type straps;
        logic [7:0] reg0;
        logic [7:0] reg1;
        csc_pkg::csc_synth_cfg_type cfg;
        // Reset request, crosses to the link domain as a level
        logic rst_req;
        // Halt pin function, kept in a flop for a clean output
        logic halt_act;
    } csc_sys_type;

    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic [3:0] en_m;
        logic [3:0] en_s;
        logic mode_m;
        logic mode_s;
        logic hh_m;
        logic hh_s;
        logic ph_m;
        logic ph_s;
        logic [3:0] host_run;
        logic gfx_run;
        logic periph_run;
    } csc_link_type;

    csc_sys_type s_ff;
    csc_sys_type nxt_s;
    csc_link_type l_ff;
    csc_link_type nxt_l;

    // Readback of the stored bytes; unimplemented ones read fixed
    function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic [7:0] r0, input logic [7:0] r1);
        if (idx == csc_pkg::REG_FREQ_SEL_CTRL)
            read_byte = r0;
        else if (idx == csc_pkg::REG_HOST_CLOCK_EN)
            read_byte = r1;
        else
            read_byte = csc_pkg::UNIMPL_READ_VALUE;
    endfunction

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    always_comb
    begin
        start_cond = s_ff.scl_s && s_ff.scl_q && s_ff.sda_q && !s_ff.sda_s;
        stop_cond = s_ff.scl_s && s_ff.scl_q && !s_ff.sda_q && s_ff.sda_s;
        scl_rise = s_ff.scl_s && !s_ff.scl_q;
        scl_fall = !s_ff.scl_s && s_ff.scl_q;

        nxt_s = s_ff;
        // Pin synchronisers; first stage feeds only the second
        nxt_s.scl_m = serial_clock_line;
        nxt_s.scl_s = s_ff.scl_m;
        nxt_s.scl_q = s_ff.scl_s;
        nxt_s.sda_m = serial_data_line_in;
        nxt_s.sda_s = s_ff.sda_m;
        nxt_s.sda_q = s_ff.sda_s;
        nxt_s.strap_m = strap_pins;
        nxt_s.strap_s = s_ff.strap_m;

        // Straps caught once, after the synchronisers have filled
        if (!s_ff.straps_ok)
        begin
            if (s_ff.strap_cnt == csc_pkg::STRAP_WAIT)
            begin
                nxt_s.straps = s_ff.strap_s; // (R23)
                nxt_s.straps_ok = 1'b1; // (R24)
            end
            else
            begin
                nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
            end
        end

        case (s_ff.st)
            csc_pkg::CSC_IDLE:
            begin
                nxt_s.sda_oe_n = 1'b1;
            end
            csc_pkg::CSC_RECV:
            begin
                if (scl_rise)
                begin
                    nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s};
                    nxt_s.cnt = s_ff.cnt + 4'h1;
                end
                else if (scl_fall && s_ff.cnt == csc_pkg::BITS_PER_BYTE)
                begin
                    nxt_s.cnt = 4'h0;
                    if (s_ff.is_addr)
                    begin
                        if (s_ff.shreg[7:1] == csc_pkg::SLAVE_ADDR)
                        begin
                            nxt_s.rw = s_ff.shreg[0];
                            nxt_s.idx = 8'h00; // (R14)
                            nxt_s.sda_oe_n = 1'b0; // (R11)
                            nxt_s.st = csc_pkg::CSC_ACK;
                        end
                        else
                        begin
                            nxt_s.st = csc_pkg::CSC_IDLE;
                        end
                    end
                    else
                    begin
                        // Command and count bytes only advance the index
                        if (s_ff.idx == csc_pkg::IDX_FIRST_REG + csc_pkg::REG_FREQ_SEL_CTRL)
                            nxt_s.reg0 = s_ff.shreg; // (R12)
                        else if (s_ff.idx == csc_pkg::IDX_FIRST_REG + csc_pkg::REG_HOST_CLOCK_EN)
                            nxt_s.reg1 = s_ff.shreg; // (R1)
                        // Later bytes fall through unstored (R25)
                        if (s_ff.idx != 8'hFF)
                            nxt_s.idx = s_ff.idx + 8'h01; // (R13)
                        nxt_s.sda_oe_n = 1'b0; // (R11)
                        nxt_s.st = csc_pkg::CSC_ACK;
                    end
                end
            end
            csc_pkg::CSC_ACK:
            begin
                // Hold the acknowledge through one whole clock pulse
                if (scl_fall)
                begin
                    nxt_s.is_addr = 1'b0;
                    if (s_ff.rw)
                    begin
                        nxt_s.shreg = read_byte(s_ff.idx, s_ff.reg0, s_ff.reg1); // (R8)
                        nxt_s.sda_oe_n = read_byte(s_ff.idx, s_ff.reg0, s_ff.reg1) >> 7 != 8'h00;
                        nxt_s.st = csc_pkg::CSC_SEND;
                    end
                    else
                    begin
                        nxt_s.sda_oe_n = 1'b1;
                        nxt_s.st = csc_pkg::CSC_RECV;
                    end
                end
            end
            csc_pkg::CSC_SEND:
            begin
                if (scl_fall)
                begin
                    if (s_ff.cnt == csc_pkg::BITS_PER_BYTE - 4'h1)
                    begin
                        nxt_s.cnt = 4'h0;
                        nxt_s.sda_oe_n = 1'b1;
                        nxt_s.st = csc_pkg::CSC_RACK;
                    end
                    else
                    begin
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                        nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
                        nxt_s.sda_oe_n = s_ff.shreg[6];
                    end
                end
            end
            csc_pkg::CSC_RACK:
            begin
                if (scl_rise)
                begin
                    nxt_s.mack = !s_ff.sda_s;
                end
                else if (scl_fall)
                begin
                    if (s_ff.mack)
                    begin
                        // Controller asked for more: next byte in order
                        nxt_s.shreg = read_byte(s_ff.idx + 8'h01, s_ff.reg0, s_ff.reg1); // (R14)
                        nxt_s.sda_oe_n = read_byte(s_ff.idx + 8'h01, s_ff.reg0, s_ff.reg1) >> 7 != 8'h00;
                        if (s_ff.idx != 8'hFF)
                            nxt_s.idx = s_ff.idx + 8'h01;
                        nxt_s.st = csc_pkg::CSC_SEND;
                    end
                    else
                    begin
                        nxt_s.st = csc_pkg::CSC_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_s.st = csc_pkg::CSC_IDLE;
                nxt_s.sda_oe_n = 1'b1;
            end
        endcase

        // Bus conditions override any byte in progress
        if (start_cond)
        begin
            nxt_s.st = csc_pkg::CSC_RECV;
            nxt_s.cnt = 4'h0;
            nxt_s.is_addr = 1'b1;
            nxt_s.sda_oe_n = 1'b1;
        end
        else if (stop_cond)
        begin
            nxt_s.st = csc_pkg::CSC_IDLE;
            nxt_s.sda_oe_n = 1'b1;
        end

        // Settings follow the stored bytes
        nxt_s.cfg.freq_code = s_ff.reg0[csc_pkg::SOFT_SEL_EN_BIT] ?
            s_ff.reg0[csc_pkg::SOFT_SEL_MSB:csc_pkg::SOFT_SEL_LSB] : s_ff.straps.strap_freq_sel; // (R17) (R18)
        nxt_s.cfg.spread_narrow = s_ff.reg0[csc_pkg::SS_NARROW_BIT]; // (R16)
        nxt_s.cfg.spread_down = s_ff.reg0[csc_pkg::SS_DOWN_BIT]; // (R19)
        nxt_s.cfg.spread_enable = s_ff.reg0[csc_pkg::SS_ENABLE_BIT]; // (R20)
        nxt_s.cfg.tristate_all = s_ff.reg0[csc_pkg::TRISTATE_BIT]; // (R21)
        nxt_s.halt_act = !s_ff.straps.mode_strap; // (R3)
        nxt_s.rst_req = 1'b0;
    end

    // Only the power-up reset loads the defaults; bus states never do
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_ff <= '0;
            s_ff.st <= csc_pkg::CSC_IDLE;
            s_ff.sda_oe_n <= 1'b1;
            s_ff.scl_m <= 1'b1;
            s_ff.scl_s <= 1'b1;
            s_ff.scl_q <= 1'b1;
            s_ff.sda_m <= 1'b1;
            s_ff.sda_s <= 1'b1;
            s_ff.sda_q <= 1'b1;
            s_ff.straps <= '1;
            s_ff.reg0 <= csc_pkg::FREQ_SEL_CTRL_RESET; // (R10) (R15)
            s_ff.reg1 <= csc_pkg::HOST_CLOCK_EN_RESET; // (R22) (R15)
            s_ff.rst_req <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Stop logic on the free-running peripheral clock
    always_comb
    begin
        nxt_l = l_ff;
        // Reset request passes two link flops before it is used
        nxt_l.rst_m = s_ff.rst_req;
        nxt_l.rst_s = l_ff.rst_m;
        // Enables are quasi-static, so a per-bit two-stage crossing will do
        nxt_l.en_m = s_ff.reg1[csc_pkg::HOST_EN_MSB:0];
        nxt_l.en_s = l_ff.en_m;
        nxt_l.mode_m = s_ff.straps.mode_strap;
        nxt_l.mode_s = l_ff.mode_m;
        nxt_l.hh_m = host_halt_n;
        nxt_l.hh_s = l_ff.hh_m;
        nxt_l.ph_m = periph_halt_n;
        nxt_l.ph_s = l_ff.ph_m;

        // Decision taken on the rising edge; the gate cell applies it at
        // the next falling edge of each clock, keeping the last high phase
        // whole and the stopped level low
        nxt_l.host_run = l_ff.en_s & {4{l_ff.mode_s || l_ff.hh_s}}; // (R3) (R4) (R6)
        nxt_l.gfx_run = l_ff.mode_s || l_ff.hh_s; // (R7) (R5)
        nxt_l.periph_run = l_ff.mode_s || l_ff.ph_s; // (R7) (R6)
    end

    always_ff @(posedge free_running_periph_clock)
    begin
        if (l_ff.rst_s)
        begin
            // Synchronisers keep filling so enables are valid on release
            l_ff <= nxt_l;
            l_ff.host_run <= '1;
            l_ff.gfx_run <= 1'b1;
            l_ff.periph_run <= 1'b1;
        end
        else
        begin
            l_ff <= nxt_l;
        end
    end

    always_comb
    begin
        serial_data_line_out = 1'b0;
        serial_data_line_oe_n = s_ff.sda_oe_n;
        synth_cfg = s_ff.cfg;
        host_output_voltage_sel = s_ff.straps.host_output_voltage_strap;
        halt_pins_active = s_ff.halt_act;
        host_clock_out_run = l_ff.host_run;
        graphics_clock_run = l_ff.gfx_run;
        periph_clock_run = l_ff.periph_run;
    end

endmodule

`default_nettype wire

// file: tb/csc_clock_control_sva.sv
`timescale 1ns/10ps
`default_nettype none
module csc_clock_control_sva
(
    // Clocks and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic free_running_periph_clock,
    // Serial pins
    input wire logic serial_clock_line,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe_n,
    // Halts and settings
    input wire logic host_halt_n,
    input wire logic periph_halt_n,
    input wire csc_pkg::csc_synth_cfg_type synth_cfg,
    input wire logic host_output_voltage_sel,
    input wire logic halt_pins_active,
    input wire logic [3:0] host_clock_out_run,
    input wire logic graphics_clock_run,
    input wire logic periph_clock_run
);
    // Straps settle a few cycles after release, so hold checks wait
    logic [3:0] up_cnt_ff;
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            up_cnt_ff <= 4'h0;
        else if (!up_cnt_ff[3])
            up_cnt_ff <= up_cnt_ff + 4'h1;
    end
    a_ack_drive_low: assert property (@(posedge clock) disable iff (sys_rst)
        !serial_data_line_oe_n |-> !serial_data_line_out) else $error("data line driven high");
    a_ack_hold_low: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(serial_data_line_oe_n) |-> !serial_data_line_oe_n [*4]) else $error("data bit too short");
    a_ack_clock_low: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(serial_data_line_oe_n) |-> !serial_clock_line) else $error("data changed with clock high");
    a_oe_reset_idle: assert property (@(posedge clock)
        sys_rst |=> serial_data_line_oe_n) else $error("data driven in reset");
    a_cfg_reset_zero: assert property (@(posedge clock)
        sys_rst |=> !synth_cfg.tristate_all && !synth_cfg.spread_enable) else $error("settings not reset");
    a_cfg_on_ack: assert property (@(posedge clock) disable iff (sys_rst)
        up_cnt_ff[3] && !$stable(synth_cfg) |-> !serial_data_line_oe_n) else $error("settings moved off ack");
    a_strap_hold_stable: assert property (@(posedge clock) disable iff (sys_rst)
        up_cnt_ff[3] |-> $stable(halt_pins_active) && $stable(host_output_voltage_sel)) else $error("strap moved");
    a_host_halt_low: assert property (@(posedge free_running_periph_clock) disable iff (sys_rst)
        (halt_pins_active && !host_halt_n) [*4] |-> host_clock_out_run == 4'h0 && !graphics_clock_run)
        else $error("host clocks not halted");
    a_periph_halt_low: assert property (@(posedge free_running_periph_clock) disable iff (sys_rst)
        (halt_pins_active && !periph_halt_n) [*4] |-> !periph_clock_run) else $error("periph clock not halted");
    a_periph_run_free: assert property (@(posedge free_running_periph_clock) disable iff (sys_rst)
        (!halt_pins_active || periph_halt_n) [*4] |-> periph_clock_run) else $error("periph clock stopped");
endmodule
`default_nettype wire

// file: tb/csc_serial_host.sv
`timescale 1ns/10ps
`default_nettype none
module csc_serial_host
#(
    parameter int SETTLE_CYCLES = 300000
)
(
    // System clock
    input wire logic clock,
    // Wire level and host drive, 1 releases
    input wire logic serial_data_line_in,
    output logic serial_clock_line,
    output logic host_sda,
    // Each byte with its acknowledge bit
    output logic res_stb,
    output logic [8:0] res_val
);
    initial
    begin
        serial_clock_line = 1'b1;
        host_sda = 1'b1;
        res_stb = 1'b0;
        res_val = 9'h000;
    end
    // Eight clocks keep each phase well above the synchroniser lag
    task half;
        repeat (8) @(posedge clock);
    endtask
    task settle;
        repeat (SETTLE_CYCLES) @(posedge clock);
    endtask
    task start_c;
        host_sda <= 1'b0;
        half();
        serial_clock_line <= 1'b0;
    endtask
    task stop_c;
        half();
        host_sda <= 1'b0;
        half();
        serial_clock_line <= 1'b1;
        half();
        host_sda <= 1'b1;
        half();
    endtask
    // Data moves mid low phase, never with the clock edge
    task bit_io(input logic b, output logic r);
        half();
        host_sda <= b;
        half();
        serial_clock_line <= 1'b1;
        half();
        r = serial_data_line_in;
        serial_clock_line <= 1'b0;
    endtask
    task byte_io(input logic [7:0] d, input logic m);
        logic [7:0] q;
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(m, a);
        res_val <= {a, q};
        res_stb <= 1'b1;
        @(posedge clock);
        res_stb <= 1'b0;
    endtask
    task write_seq(input logic [7:0] cmd, cnt, r0, r1, xtra);
        start_c();
        byte_io({csc_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
        byte_io(cmd, 1'b1);
        byte_io(cnt, 1'b1);
        byte_io(r0, 1'b1);
        byte_io(r1, 1'b1);
        byte_io(xtra, 1'b1);
        stop_c();
    endtask
    task read_seq(input int n);
        start_c();
        byte_io({csc_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++)
            byte_io(8'hFF, i == n - 1);
        stop_c();
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock, link_clk, sys_rst, host_halt_n, periph_halt_n, scl, host_sda, sda_out, sda_oe_n, sda_wire;
    logic res_stb, gfx_run, per_run, volt_sel, halt_act;
    logic [8:0] res_val;
    logic [3:0] run;
    logic [7:0] r0, r1, c;
    logic [2:0] strap_f;
    csc_pkg::csc_strap_type straps;
    csc_pkg::csc_synth_cfg_type cfg, exp_cfg;
    logic [8:0] exp_q[$];
    int fail_count, compares;
    integer seed;
    // Pull-up wire, either side may pull low
    assign sda_wire = host_sda & (sda_oe_n | sda_out);
    csc_clock_control dut_u (.clock(clock), .sys_rst(sys_rst), .free_running_periph_clock(link_clk),
        .serial_clock_line(scl), .serial_data_line_in(sda_wire), .serial_data_line_out(sda_out),
        .serial_data_line_oe_n(sda_oe_n), .strap_pins(straps), .host_halt_n(host_halt_n),
        .periph_halt_n(periph_halt_n), .synth_cfg(cfg), .host_output_voltage_sel(volt_sel),
        .halt_pins_active(halt_act), .host_clock_out_run(run), .graphics_clock_run(gfx_run),
        .periph_clock_run(per_run));
    csc_serial_host #(.SETTLE_CYCLES(20)) host_u (.clock(clock), .serial_data_line_in(sda_wire),
        .serial_clock_line(scl), .host_sda(host_sda), .res_stb(res_stb), .res_val(res_val));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    task cmp(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock)
        if (res_stb === 1'b1)
            cmp(res_val, exp_q.pop_front());
    task links(input int n);
        repeat (n) @(posedge link_clk);
        @(posedge clock);
    endtask
    // Link side needs four of its edges in reset, hence six clocks
    task do_reset(input logic [4:0] s);
        @(posedge clock);
        straps <= s;
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        strap_f = s[2:0];
        host_u.settle();
        straps <= 5'($random(seed));
    endtask
    task rd(input logic [7:0] a, b);
        exp_q.push_back({1'b0, 8'hD3});
        exp_q.push_back({1'b0, a});
        exp_q.push_back({1'b0, b});
        exp_q.push_back({1'b1, 8'h00});
        host_u.read_seq(3);
    endtask
    task check_defaults(input logic volt, act);
        rd(8'h00, 8'hFF);
        links(5);
        cmp({2'b0, cfg}, {2'b0, strap_f, 4'h0});
        cmp({7'h0, volt_sel, halt_act}, {7'h0, volt, act});
        cmp({3'h0, run, gfx_run, per_run}, 9'h03F);
    endtask
    initial
    begin
        seed = 32'h027ECDFC;
        fail_count = 0;
        compares = 0;
        sys_rst = 1'b1;
        host_halt_n = 1'b1;
        periph_halt_n = 1'b1;
        straps = '1;
        do_reset(5'b00101);
        check_defaults(1'b0, 1'b1);
        exp_q.push_back({1'b1, 8'hA4});
        host_u.start_c();
        host_u.byte_io(8'hA4, 1'b1);
        host_u.stop_c();
        for (int i = 0; i < 8; i++)
        begin
            r0 = 8'($random(seed));
            r0[6:4] = i[2:0];
            r1 = {4'hF, 4'($random(seed))};
            c = 8'($random(seed));
            cmp(9'(exp_q.size()), 9'h000);
            exp_q.push_back({1'b0, 8'hD2});
            exp_q.push_back({1'b0, c});
            exp_q.push_back({1'b0, ~c});
            exp_q.push_back({1'b0, r0});
            exp_q.push_back({1'b0, r1});
            exp_q.push_back({1'b0, c ^ r0});
            host_u.write_seq(c, ~c, r0, r1, c ^ r0);
            links(5);
            exp_cfg = {r0[3] ? r0[6:4] : strap_f, r0[1], r0[2], r0[7], r0[0]};
            cmp({2'b0, cfg}, {2'b0, exp_cfg});
            cmp({5'h0, run}, {5'h0, r1[3:0]});
            rd(r0, r1);
        end
        host_halt_n <= 1'b0;
        links(5);
        cmp({3'h0, run, gfx_run, per_run}, 9'h001);
        periph_halt_n <= 1'b0;
        links(5);
        cmp({3'h0, run, gfx_run, per_run}, 9'h000);
        host_halt_n <= 1'b1;
        links(5);
        cmp({3'h0, run, gfx_run, per_run}, {3'h0, r1[3:0], 2'b10});
        periph_halt_n <= 1'b1;
        do_reset(5'b11010);
        check_defaults(1'b1, 1'b0);
        host_halt_n <= 1'b0;
        periph_halt_n <= 1'b0;
        links(5);
        cmp({3'h0, run, gfx_run, per_run}, 9'h03F);
        cmp(9'(exp_q.size()), 9'h000);
        summarize();
    end
    initial
    begin
        #600000;
        fail_count++;
        summarize();
    end
endmodule
bind csc_clock_control csc_clock_control_sva chk_u (.clock, .sys_rst, .free_running_periph_clock,
    .serial_clock_line, .serial_data_line_out, .serial_data_line_oe_n, .host_halt_n, .periph_halt_n,
    .synth_cfg, .host_output_voltage_sel, .halt_pins_active, .host_clock_out_run, .graphics_clock_run,
    .periph_clock_run);
`default_nettype wire
